// file: umo_mode_output.sv
// Mode-register pointers, mode-one fields and output-pin function select
`include "umo_map.svh"
`default_nettype none
// What this block does
// - Pin zero: general purpose, or channel A receive/transmit request-to-send.
// - Pin one: same selection for channel B.
// - Pin two chosen by config bits 1:0 among general and channel A clocks.
// - Pin three chosen by config bits 3:2; counter-ready or timer by aux bit 6.
// - Pin four: channel A receive-ready or FIFO-full when config bit 4 set.
// - Pin five: channel B receive-ready or FIFO-full when config bit 5 set.
// - Each channel pointer goes to mode one at reset or reset-pointer command.
// - Mode access while pointer at mode one moves it to mode two.
// - Mode and command registers are separate per channel.
// - Mode one bit 7 enables receiver request-to-send flow control.
// - Mode one bit 6 selects receive-ready or FIFO-full as receive interrupt.
// - Mode one bit 5 selects per-character or block error reporting.
// - Mode one bits 4:3 select parity mode.
// - Mode one bit 2 gives parity type, forced level or address mark.
module umo_mode_output
   import umo_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register bus, synchronous to ref_clk
   input wire logic bus_sel,
   input wire logic bus_read,
   input wire logic bus_write,
   input wire logic [3:0] bus_reg_sel,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   // Internal sources for the output pins
   input wire logic chan_a_receive_ready,
   input wire logic chan_b_receive_ready,
   input wire logic chan_a_fifo_full,
   input wire logic chan_b_fifo_full,
   input wire logic chan_a_transmit_ready,
   input wire logic chan_b_transmit_ready,
   input wire logic chan_a_receive_flow_request,
   input wire logic chan_b_receive_flow_request,
   input wire logic chan_a_transmit_flow_request,
   input wire logic chan_b_transmit_flow_request,
   input wire logic chan_a_transmit_16x_clock,
   input wire logic chan_a_transmit_baud_clock,
   input wire logic chan_a_receive_baud_clock,
   input wire logic chan_b_transmit_baud_clock,
   input wire logic chan_b_receive_baud_clock,
   input wire logic counter_ready_flag,
   input wire logic timer_output,
   // Decoded mode fields for the serial datapaths
   output logic chan_a_rx_rts_enable,
   output logic chan_b_rx_rts_enable,
   output logic chan_a_rx_irq_fifo_full,
   output logic chan_b_rx_irq_fifo_full,
   output logic chan_a_block_error,
   output logic chan_b_block_error,
   output umo_parity_e chan_a_parity_mode,
   output umo_parity_e chan_b_parity_mode,
   output logic chan_a_parity_type,
   output logic chan_b_parity_type,
   output logic [1:0] chan_a_char_len,
   output logic [1:0] chan_b_char_len,
   output logic [7:0] chan_a_mode_two,
   output logic [7:0] chan_b_mode_two,
   output logic chan_a_ptr_at_two,
   output logic chan_b_ptr_at_two,
   // Output port pins
   output logic output_pin_zero,
   output logic output_pin_one,
   output logic output_pin_two,
   output logic output_pin_three,
   output logic output_pin_four,
   output logic output_pin_five,
   output logic output_pin_six,
   output logic output_pin_seven
);
   logic [7:0] channel_a_mode_one_q;
   logic [7:0] channel_b_mode_one_q;
   logic [7:0] channel_a_mode_two_q;
   logic [7:0] channel_b_mode_two_q;
   logic [7:0] output_pin_config_q;
   logic [7:0] auxiliary_control_q;
   logic [7:0] gp_out_q;
   logic ptr_a_q;
   logic ptr_b_q;
   logic [7:0] pins_d;
   logic [7:0] pins_q;
   logic [7:0] rdata_d;
   logic wr;
   logic rd;
   logic mode_a_acc;
   logic mode_b_acc;
   logic rst_ptr_a;
   logic rst_ptr_b;
   umo_op2_sel_e op2_sel;
   umo_op3_sel_e op3_sel;

   assign wr = bus_sel && bus_write;
   assign rd = bus_sel && bus_read && !bus_write;
   assign mode_a_acc = (wr || rd) && bus_reg_sel == `UMO_RS_MODE_A;
   assign mode_b_acc = (wr || rd) && bus_reg_sel == `UMO_RS_MODE_B;
   assign rst_ptr_a = wr && bus_reg_sel == `UMO_RS_CMD_A &&
      bus_wdata[`UMO_CMD_MISC_MSB:`UMO_CMD_MISC_LSB] == `UMO_CMD_RESET_PTR;
   assign rst_ptr_b = wr && bus_reg_sel == `UMO_RS_CMD_B &&
      bus_wdata[`UMO_CMD_MISC_MSB:`UMO_CMD_MISC_LSB] == `UMO_CMD_RESET_PTR;

   // Pointer per channel; reset command wins over a same-cycle access
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr_a_q <= 1'b0;
         ptr_b_q <= 1'b0;
      end else begin
         if (rst_ptr_a)
            ptr_a_q <= 1'b0;
         else if (mode_a_acc)
            ptr_a_q <= 1'b1;
         if (rst_ptr_b)
            ptr_b_q <= 1'b0;
         else if (mode_b_acc)
            ptr_b_q <= 1'b1;
      end
   end

   // Separate mode registers per channel
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         channel_a_mode_one_q <= `UMO_REG_RESET;
         channel_b_mode_one_q <= `UMO_REG_RESET;
         channel_a_mode_two_q <= `UMO_REG_RESET;
         channel_b_mode_two_q <= `UMO_REG_RESET;
      end else if (wr) begin
         if (bus_reg_sel == `UMO_RS_MODE_A) begin
            if (ptr_a_q)
               channel_a_mode_two_q <= bus_wdata;
            else
               channel_a_mode_one_q <= bus_wdata;
         end
         if (bus_reg_sel == `UMO_RS_MODE_B) begin
            if (ptr_b_q)
               channel_b_mode_two_q <= bus_wdata;
            else
               channel_b_mode_one_q <= bus_wdata;
         end
      end
   end

   // Config, aux control and general-purpose output bits
   // No guard against changes mid-character; software must quiesce the channels first
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         output_pin_config_q <= `UMO_REG_RESET;
         auxiliary_control_q <= `UMO_REG_RESET;
         gp_out_q <= `UMO_REG_RESET;
      end else if (wr) begin
         case (bus_reg_sel)
            `UMO_RS_OUT_CFG: output_pin_config_q <= bus_wdata;
            `UMO_RS_AUX_CTRL: auxiliary_control_q <= bus_wdata;
            `UMO_RS_OUT_SET: gp_out_q <= gp_out_q | bus_wdata;
            `UMO_RS_OUT_CLR: gp_out_q <= gp_out_q & ~bus_wdata;
            default: gp_out_q <= gp_out_q;
         endcase
      end
   end

   // Read data: mode address returns the register the pointer selects
   always_comb begin
      rdata_d = 8'h00;
      case (bus_reg_sel)
         `UMO_RS_MODE_A: rdata_d = ptr_a_q ? channel_a_mode_two_q : channel_a_mode_one_q;
         `UMO_RS_MODE_B: rdata_d = ptr_b_q ? channel_b_mode_two_q : channel_b_mode_one_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         bus_rdata <= 8'h00;
      else if (rd)
         bus_rdata <= rdata_d;
   end

   assign op2_sel = umo_op2_sel_e'(output_pin_config_q[1:0]);
   assign op3_sel = umo_op3_sel_e'(output_pin_config_q[3:2]);

   // Pin function muxes; transmit request outranks receive if both enabled
   always_comb begin
      pins_d = gp_out_q;
      if (channel_a_mode_two_q[`UMO_MR2_TX_RTS])
         pins_d[0] = chan_a_transmit_flow_request;
      else if (channel_a_mode_one_q[`UMO_MR1_RX_RTS])
         pins_d[0] = chan_a_receive_flow_request;
      if (channel_b_mode_two_q[`UMO_MR2_TX_RTS])
         pins_d[1] = chan_b_transmit_flow_request;
      else if (channel_b_mode_one_q[`UMO_MR1_RX_RTS])
         pins_d[1] = chan_b_receive_flow_request;
      case (op2_sel)
         UMO_OP2_TX16_A: pins_d[2] = chan_a_transmit_16x_clock;
         UMO_OP2_TX1_A: pins_d[2] = chan_a_transmit_baud_clock;
         UMO_OP2_RX1_A: pins_d[2] = chan_a_receive_baud_clock;
         default: pins_d[2] = gp_out_q[2];
      endcase
      case (op3_sel)
         UMO_OP3_CT: pins_d[3] = auxiliary_control_q[`UMO_ACR_TIMER_OUT] ?
            timer_output : counter_ready_flag;
         UMO_OP3_TX1_B: pins_d[3] = chan_b_transmit_baud_clock;
         UMO_OP3_RX1_B: pins_d[3] = chan_b_receive_baud_clock;
         default: pins_d[3] = gp_out_q[3];
      endcase
      if (output_pin_config_q[4])
         pins_d[4] = channel_a_mode_one_q[`UMO_MR1_RX_IRQ_SEL] ?
            chan_a_fifo_full : chan_a_receive_ready;
      if (output_pin_config_q[5])
         pins_d[5] = channel_b_mode_one_q[`UMO_MR1_RX_IRQ_SEL] ?
            chan_b_fifo_full : chan_b_receive_ready;
      if (output_pin_config_q[6])
         pins_d[6] = chan_a_transmit_ready;
      if (output_pin_config_q[7])
         pins_d[7] = chan_b_transmit_ready;
   end

   // Registered pins; one cycle of latency keeps glitches off the pads
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         pins_q <= 8'h00;
      else
         pins_q <= pins_d;
   end

   assign output_pin_zero = pins_q[0];
   assign output_pin_one = pins_q[1];
   assign output_pin_two = pins_q[2];
   assign output_pin_three = pins_q[3];
   assign output_pin_four = pins_q[4];
   assign output_pin_five = pins_q[5];
   assign output_pin_six = pins_q[6];
   assign output_pin_seven = pins_q[7];

   assign chan_a_rx_rts_enable = channel_a_mode_one_q[`UMO_MR1_RX_RTS];
   assign chan_b_rx_rts_enable = channel_b_mode_one_q[`UMO_MR1_RX_RTS];
   assign chan_a_rx_irq_fifo_full = channel_a_mode_one_q[`UMO_MR1_RX_IRQ_SEL];
   assign chan_b_rx_irq_fifo_full = channel_b_mode_one_q[`UMO_MR1_RX_IRQ_SEL];
   assign chan_a_block_error = channel_a_mode_one_q[`UMO_MR1_ERR_MODE];
   assign chan_b_block_error = channel_b_mode_one_q[`UMO_MR1_ERR_MODE];
   assign chan_a_parity_mode = umo_parity_e'(
      channel_a_mode_one_q[`UMO_MR1_PAR_MSB:`UMO_MR1_PAR_LSB]);
   assign chan_b_parity_mode = umo_parity_e'(
      channel_b_mode_one_q[`UMO_MR1_PAR_MSB:`UMO_MR1_PAR_LSB]);
   assign chan_a_parity_type = channel_a_mode_one_q[`UMO_MR1_PAR_TYPE];
   assign chan_b_parity_type = channel_b_mode_one_q[`UMO_MR1_PAR_TYPE];
   assign chan_a_char_len = channel_a_mode_one_q[`UMO_MR1_LEN_MSB:`UMO_MR1_LEN_LSB];
   assign chan_b_char_len = channel_b_mode_one_q[`UMO_MR1_LEN_MSB:`UMO_MR1_LEN_LSB];
   assign chan_a_mode_two = channel_a_mode_two_q;
   assign chan_b_mode_two = channel_b_mode_two_q;
   assign chan_a_ptr_at_two = ptr_a_q;
   assign chan_b_ptr_at_two = ptr_b_q;
endmodule : umo_mode_output
`default_nettype wire

// file: umo_map.svh
// Register selects, field positions and reset values for the mode and output-select block
`ifndef UMO_MAP_SVH
`define UMO_MAP_SVH
`define UMO_RS_MODE_A 4'h0
`define UMO_RS_CMD_A 4'h2
`define UMO_RS_AUX_CTRL 4'h4
`define UMO_RS_MODE_B 4'h8
`define UMO_RS_CMD_B 4'hA
`define UMO_RS_OUT_CFG 4'hD
`define UMO_RS_OUT_SET 4'hE
`define UMO_RS_OUT_CLR 4'hF
`define UMO_CMD_MISC_MSB 6
`define UMO_CMD_MISC_LSB 4
`define UMO_CMD_RESET_PTR 3'h1
`define UMO_MR1_RX_RTS 7
`define UMO_MR1_RX_IRQ_SEL 6
`define UMO_MR1_ERR_MODE 5
`define UMO_MR1_PAR_MSB 4
`define UMO_MR1_PAR_LSB 3
`define UMO_MR1_PAR_TYPE 2
`define UMO_MR1_LEN_MSB 1
`define UMO_MR1_LEN_LSB 0
`define UMO_MR2_TX_RTS 5
`define UMO_ACR_TIMER_OUT 6
`define UMO_REG_RESET 8'h00
`endif

// file: umo_pkg.sv
// Types shared by the mode and output-select block
`default_nettype none
package umo_pkg;
   typedef enum logic [1:0] {
      UMO_PAR_WITH = 2'h0,
      UMO_PAR_FORCE = 2'h1,
      UMO_PAR_NONE = 2'h2,
      UMO_PAR_MULTIDROP = 2'h3
   } umo_parity_e;
   typedef enum logic [1:0] {
      UMO_OP2_GP = 2'h0,
      UMO_OP2_TX16_A = 2'h1,
      UMO_OP2_TX1_A = 2'h2,
      UMO_OP2_RX1_A = 2'h3
   } umo_op2_sel_e;
   typedef enum logic [1:0] {
      UMO_OP3_GP = 2'h0,
      UMO_OP3_CT = 2'h1,
      UMO_OP3_TX1_B = 2'h2,
      UMO_OP3_RX1_B = 2'h3
   } umo_op3_sel_e;
endpackage : umo_pkg
`default_nettype wire

// file: umo_host.sv
// Host model issuing register bus cycles
`default_nettype none
module umo_host (
   // Clock
   input wire logic ref_clk,
   // Register bus
   output logic bus_sel,
   output logic bus_read,
   output logic bus_write,
   output logic [3:0] bus_reg_sel,
   output logic [7:0] bus_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {bus_sel, bus_read, bus_write, bus_reg_sel, bus_wdata} = '0;
   end
   // Setup writes and reads, with channels idle and counter unused
   task acc(input logic w, input logic [3:0] rs, input logic [7:0] d);
      @(posedge ref_clk);
      bus_sel <= 1'h1;
      bus_write <= w;
      bus_read <= !w;
      bus_reg_sel <= rs;
      bus_wdata <= d;
      @(posedge ref_clk);
      bus_sel <= 1'h0;
      bus_write <= 1'h0;
      bus_read <= 1'h0;
      // Released data lines must not keep the last value
      bus_wdata <= ~d;
   endtask : acc
endmodule : umo_host
`default_nettype wire

// file: umo_props.sv
// Checker for the mode pointer, mode-one fields and pin zero
`default_nettype none
module umo_props
   import umo_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register bus
   input wire logic bus_sel,
   input wire logic bus_read,
   input wire logic bus_write,
   input wire logic [3:0] bus_reg_sel,
   input wire logic [7:0] bus_wdata,
   // Channel A mode state and channel B pointer
   input wire logic chan_a_rx_rts_enable,
   input wire logic chan_a_rx_irq_fifo_full,
   input wire logic chan_a_block_error,
   input wire umo_parity_e chan_a_parity_mode,
   input wire logic chan_a_parity_type,
   input wire logic [1:0] chan_a_char_len,
   input wire logic [7:0] chan_a_mode_two,
   input wire logic chan_a_ptr_at_two,
   input wire logic chan_b_ptr_at_two,
   // Pin zero
   input wire logic chan_a_receive_flow_request,
   input wire logic chan_a_transmit_flow_request,
   input wire logic output_pin_zero
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] m1a;
   logic acc_a;
   logic cmd_a;
   assign m1a = {chan_a_rx_rts_enable, chan_a_rx_irq_fifo_full, chan_a_block_error,
      chan_a_parity_mode, chan_a_parity_type, chan_a_char_len};
   assign acc_a = bus_sel && (bus_read || bus_write) && bus_reg_sel == 4'h0;
   assign cmd_a = bus_sel && bus_write && bus_reg_sel == 4'h2;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   a_ptr_moves: assert property (acc_a && !chan_a_ptr_at_two |=> chan_a_ptr_at_two)
      else $error("pointer A stayed at mode one");
   a_ptr_stays: assert property (chan_a_ptr_at_two && !cmd_a |=> chan_a_ptr_at_two)
      else $error("pointer A left mode two");
   a_ptr_resets: assert property (cmd_a && bus_wdata[6:4] == 3'h1 |=> !chan_a_ptr_at_two)
      else $error("pointer A not reset");
   a_chan_indep: assert property (acc_a |=> $stable(chan_b_ptr_at_two))
      else $error("pointer B moved on channel A access");
   a_ptr_b_moves: assert property (
      bus_sel && (bus_read || bus_write) && bus_reg_sel == 4'h8 && !chan_b_ptr_at_two
      |=> chan_b_ptr_at_two)
      else $error("pointer B stayed at mode one");
   a_mode_one_load: assert property (
      acc_a && bus_write && !chan_a_ptr_at_two |=> m1a == $past(bus_wdata))
      else $error("mode one A fields wrong");
   a_mode_two_load: assert property (
      acc_a && bus_write && chan_a_ptr_at_two |=> chan_a_mode_two == $past(bus_wdata))
      else $error("mode two A not loaded");
   a_pin_zero_tx: assert property (
      chan_a_mode_two[5] |=> output_pin_zero == $past(chan_a_transmit_flow_request))
      else $error("pin zero not transmit request");
   a_pin_zero_rx: assert property (
      !chan_a_mode_two[5] && chan_a_rx_rts_enable
      |=> output_pin_zero == $past(chan_a_receive_flow_request))
      else $error("pin zero not receive request");
   cover property (acc_a && bus_write);
   cover property (chan_a_ptr_at_two ##1 !chan_a_ptr_at_two);
   cover property (output_pin_zero);
endmodule : umo_props
bind umo_mode_output umo_props u_props (.ref_clk(ref_clk), .reset_n(reset_n),
   .bus_sel(bus_sel), .bus_read(bus_read), .bus_write(bus_write),
   .bus_reg_sel(bus_reg_sel), .bus_wdata(bus_wdata),
   .chan_a_rx_rts_enable(chan_a_rx_rts_enable), .chan_a_rx_irq_fifo_full(chan_a_rx_irq_fifo_full),
   .chan_a_block_error(chan_a_block_error), .chan_a_parity_mode(chan_a_parity_mode),
   .chan_a_parity_type(chan_a_parity_type), .chan_a_char_len(chan_a_char_len),
   .chan_a_mode_two(chan_a_mode_two), .chan_a_ptr_at_two(chan_a_ptr_at_two),
   .chan_b_ptr_at_two(chan_b_ptr_at_two),
   .chan_a_receive_flow_request(chan_a_receive_flow_request),
   .chan_a_transmit_flow_request(chan_a_transmit_flow_request),
   .output_pin_zero(output_pin_zero));
`default_nettype wire

// file: umo_mode_output_tb.sv
// Testbench for the mode and output-select block
`default_nettype none
module umo_mode_output_tb;
   import umo_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MA = 8'hD5;
   localparam logic [7:0] MB = 8'h80;
   localparam logic [7:0] TA = 8'h20;
   localparam logic [7:0] GP = 8'hA5;
   logic ref_clk = 1'h0;
   logic reset_n = 1'h0;
   logic [16:0] s = '0;
   wire logic bus_sel, bus_read, bus_write, pa, pb;
   wire logic [3:0] bus_reg_sel;
   wire logic [7:0] bus_wdata, bus_rdata, pins;
   wire logic [7:0] mfb, m2b;
   int num_errors = 0;
   int total_checks = 0;
   always #5 ref_clk = ~ref_clk;
   umo_host host (.ref_clk(ref_clk), .bus_sel(bus_sel), .bus_read(bus_read),
      .bus_write(bus_write), .bus_reg_sel(bus_reg_sel), .bus_wdata(bus_wdata));
   umo_mode_output dut (.ref_clk(ref_clk), .reset_n(reset_n), .bus_sel(bus_sel),
      .bus_read(bus_read), .bus_write(bus_write), .bus_reg_sel(bus_reg_sel),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .chan_a_receive_ready(s[0]), .chan_b_receive_ready(s[1]), .chan_a_fifo_full(s[2]),
      .chan_b_fifo_full(s[3]), .chan_a_transmit_ready(s[4]), .chan_b_transmit_ready(s[5]),
      .chan_a_receive_flow_request(s[6]), .chan_b_receive_flow_request(s[7]),
      .chan_a_transmit_flow_request(s[8]), .chan_b_transmit_flow_request(s[9]),
      .chan_a_transmit_16x_clock(s[10]), .chan_a_transmit_baud_clock(s[11]),
      .chan_a_receive_baud_clock(s[12]), .chan_b_transmit_baud_clock(s[13]),
      .chan_b_receive_baud_clock(s[14]), .counter_ready_flag(s[15]), .timer_output(s[16]),
      .chan_a_rx_rts_enable(), .chan_b_rx_rts_enable(mfb[7]), .chan_a_rx_irq_fifo_full(),
      .chan_b_rx_irq_fifo_full(mfb[6]), .chan_a_block_error(), .chan_b_block_error(mfb[5]),
      .chan_a_parity_mode(), .chan_b_parity_mode(mfb[4:3]), .chan_a_parity_type(),
      .chan_b_parity_type(mfb[2]), .chan_a_char_len(), .chan_b_char_len(mfb[1:0]),
      .chan_a_mode_two(), .chan_b_mode_two(m2b), .chan_a_ptr_at_two(pa),
      .chan_b_ptr_at_two(pb),
      .output_pin_zero(pins[0]), .output_pin_one(pins[1]), .output_pin_two(pins[2]),
      .output_pin_three(pins[3]), .output_pin_four(pins[4]), .output_pin_five(pins[5]),
      .output_pin_six(pins[6]), .output_pin_seven(pins[7]));
   task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         $display("BAD %s exp %h seen %h", n, exp, seen);
         num_errors++;
      end
   endtask : chk
   task rd(input logic [3:0] r, input logic [7:0] e, input string n);
      host.acc(1'h0, r, 8'h00);
      #1;
      chk(n, bus_rdata, e);
   endtask : rd
   // Modes fixed by t_pointer: A has both requests on, B receive request only
   function automatic logic [7:0] pexp(input logic [7:0] c, input logic t);
      logic [7:0] p;
      p[0] = TA[5] ? s[8] : s[6];
      p[1] = MB[7] ? s[7] : GP[1];
      p[2] = c[1:0] == 2'h0 ? GP[2] : s[9 + c[1:0]];
      p[3] = c[3:2] == 2'h0 ? GP[3] : c[3:2] == 2'h1 ? s[15 + t] : s[11 + c[3:2]];
      p[4] = c[4] ? (MA[6] ? s[2] : s[0]) : GP[4];
      p[5] = c[5] ? (MB[6] ? s[3] : s[1]) : GP[5];
      p[6] = c[6] ? s[4] : GP[6];
      p[7] = c[7] ? s[5] : GP[7];
      return p;
   endfunction : pexp
   task t_reset;
      #1;
      chk("pins", pins, 8'h00);
      chk("ptr", {6'h00, pa, pb}, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task t_pointer;
      host.acc(1'h1, 4'h0, MA);
      #1;
      chk("ptr_ab", {6'h00, pa, pb}, 8'h02);
      host.acc(1'h1, 4'h0, TA);
      rd(4'h0, TA, "mode_two_a");
      host.acc(1'h1, 4'h2, 8'h10);
      #1;
      chk("ptr_rst", {6'h00, pa, pb}, 8'h00);
      rd(4'h0, MA, "mode_one_a");
      host.acc(1'h1, 4'h8, MB);
      rd(4'h8, 8'h00, "mode_two_b");
      $display("test pointer done");
   endtask : t_pointer
   task t_pins;
      logic [7:0] c;
      host.acc(1'h1, 4'hE, GP);
      for (int i = 0; i < 8; i++) begin
         c = {{4{i[2]}}, i[1:0], i[1:0]};
         host.acc(1'h1, 4'hD, c);
         host.acc(1'h1, 4'h4, {1'h0, i[2], 6'h00});
         for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            s <= k ? 17'h0AAAA : 17'h15555;
            repeat (2) @(posedge ref_clk);
            #1;
            chk("pins", pins, pexp(c, i[2]));
         end
      end
      $display("test pins done");
   endtask : t_pins
   // A: receive request and receive-ready; B: transmit request and FIFO-full
   task t_modes;
      host.acc(1'h1, 4'h2, 8'h10);
      host.acc(1'h1, 4'h0, 8'h95);
      host.acc(1'h1, 4'h0, 8'h00);
      host.acc(1'h1, 4'hA, 8'h10);
      host.acc(1'h1, 4'h8, 8'hDE);
      host.acc(1'h1, 4'h8, 8'h20);
      #1;
      chk("mode_one_b", mfb, 8'hDE);
      chk("mode_two_b", m2b, 8'h20);
      host.acc(1'h1, 4'hD, 8'h30);
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         s <= k ? 17'h0AAAA : 17'h15555;
         repeat (2) @(posedge ref_clk);
         #1;
         chk("pins_modes", pins, {GP[7:6], s[3], s[0], GP[3:2], s[9], s[6]});
      end
      // Hardware reset in mid-run with both pointers at mode two
      @(posedge ref_clk);
      reset_n <= 1'h0;
      #1;
      chk("ptr_hw_rst", {6'h00, pa, pb}, 8'h00);
      chk("pins_hw_rst", pins, 8'h00);
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'h1;
      rd(4'h0, 8'h00, "mode_one_a_rst");
      chk("ptr_after_rd", {6'h00, pa, pb}, 8'h02);
      $display("test modes done");
   endtask : t_modes
   task conclude;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'h1;
      t_reset;
      t_pointer;
      t_pins;
      t_modes;
      conclude;
   end
endmodule : umo_mode_output_tb
`default_nettype wire
